// [slm_defines.vh]
// constants for the serial loop multiplexer
// Contract
// - unsynchronized input loop bits pass unchanged
// - hunt loop end plus empty, 24 bits
// - replace detected loop end with empty
// - synchronized: stop latching new adapter requests
// - lowest slot number wins the grant
// - 32 request lines in, 32 selects out
// - end frame on last byte or 16 cells
// - frames follow back to back, no gaps
// - overwrite cells with bytes, close with checksum
// - empty next cell: serve next pending adapter
// - busy next cell: checksum, loop end, unsync
// - all served: loop end, empty, then unsync
// - checksum poly x8+x7+x6+x+1, through id nibble
// - restart cell flags error to last sender
// - output loop syncs on empty, frames at address
// - broadcast address, pass cells until checksum
// - checksum mismatch flagged at frame end, same cycle
// - regenerate loop clock, forward loop data
// - cells are 12 bits, clock plus data
// - over 16 output cells: error, disconnect
`ifndef SLM_DEFINES_VH
`define SLM_DEFINES_VH

// ****************************************
// cell layout: id in [11:8], payload [7:0], msb sent first
// ****************************************
`define SLM_CELL_MSB 11
`define SLM_LAST_BIT 4'hb
`define SLM_ID_EMPTY 4'h0
`define SLM_ID_NULL 4'h1
`define SLM_ID_ADDR 4'h2
`define SLM_ID_DATA 4'h3
`define SLM_ID_CHK 4'h4
`define SLM_ID_LOOP_END 4'he
`define SLM_ID_RESTART 4'hf
`define SLM_CELL_EMPTY 12'h000
`define SLM_CELL_LOOP_END 12'he00
`define SLM_CELL_RESTART 12'hf00
`define SLM_SYNC_PAT 24'he0_0000

// ****************************************
// checksum and frame limits
// ****************************************
`define SLM_CRC_POLY 8'hc3
`define SLM_CRC_ID_BITS 4'h4
`define SLM_CELL_BITS 4'hc
`define SLM_MAX_CELLS 5'h10
`define SLM_LAST_BYTE 4'hf

// ****************************************
// timing
// ****************************************
`define SLM_SYS_NS 10
`define SLM_LINK_HALF_NS 40
`define SLM_REGEN_CYC (`SLM_LINK_HALF_NS / `SLM_SYS_NS)

`endif

// [slm_link_rx.v]
// loop link receiver: synchroniser, bit strobe and clock regeneration
`timescale 1ns/100ps
`include "slm_defines.vh"

module slm_link_rx (
    input wire clk_i,
    input wire rstn_i,
    input wire lclk_i,
    input wire ldat_i,
    output reg bit_stb_o,
    output reg bit_o,
    output wire lclk_o
);
    localparam DLY = `SLM_REGEN_CYC;

    reg clk_s1_r;
    reg clk_s2_r;
    reg clk_s3_r;
    reg dat_s1_r;
    reg dat_s2_r;
    reg [DLY-1:0] dly_r;

    // ****************************************
    // two-stage sync, rising edge of link clock
    // ****************************************
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clk_s1_r <= 1'b0;
            clk_s2_r <= 1'b0;
            clk_s3_r <= 1'b0;
            dat_s1_r <= 1'b0;
            dat_s2_r <= 1'b0;
            bit_stb_o <= 1'b0;
            bit_o <= 1'b0;
            dly_r <= {DLY{1'b0}};
        end else begin
            clk_s1_r <= lclk_i;
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r;
            dat_s1_r <= ldat_i;
            dat_s2_r <= dat_s1_r;
            bit_stb_o <= clk_s2_r & ~clk_s3_r;
            if (clk_s2_r & ~clk_s3_r) begin
                bit_o <= dat_s2_r;
            end
            // delayed copy puts the regenerated edge mid-bit
            dly_r <= {dly_r[DLY-2:0], clk_s2_r};
        end
    end

    assign lclk_o = dly_r[DLY-1];
endmodule

// [slm_loop_mux.v]
// serial loop multiplexer: input loop framer and output loop distributor
`timescale 1ns/100ps
`include "slm_defines.vh"

module slm_loop_mux (
    input wire clk_i,
    input wire rstn_i,
    input wire in_clk_i,
    input wire in_dat_i,
    output reg in_clk_o,
    output reg in_dat_o,
    input wire out_clk_i,
    input wire out_dat_i,
    output reg out_clk_o,
    output reg out_dat_o,
    input wire [31:0] req_i,
    input wire [10:0] in_byte_i,
    input wire in_last_i,
    output reg [31:0] in_sel_o,
    output reg in_stb_o,
    output reg [31:0] in_err_o,
    output reg in_sync_o,
    output reg [10:0] obus_data_o,
    output reg obus_addr_stb_o,
    output reg obus_data_stb_o,
    output reg obus_end_o,
    output reg obus_err_o,
    output reg out_sync_o
);
    localparam ST_HUNT = 7'b000_0001;
    localparam ST_FIRST = 7'b000_0010;
    localparam ST_FRAME = 7'b000_0100;
    localparam ST_CRC = 7'b000_1000;
    localparam ST_END = 7'b001_0000;
    localparam ST_TAIL = 7'b010_0000;
    localparam ST_ENDX = 7'b100_0000;

    // ****************************************
    // shared arithmetic
    // ****************************************
    function [7:0] crc_bits;
        input [7:0] c;
        input [11:0] d;
        input [3:0] n;
        integer i;
        reg [7:0] a;
        reg fb;
        begin
            a = c;
            for (i = 0; i < 12; i = i + 1) begin
                if (i < n) begin
                    fb = a[7] ^ d[11-i];
                    a = {a[6:0], 1'b0} ^ (fb ? `SLM_CRC_POLY : 8'h00);
                end
            end
            crc_bits = a;
        end
    endfunction

    function [4:0] pick_slot;
        input [31:0] p;
        integer i;
        begin
            pick_slot = 5'h00;
            for (i = 31; i >= 0; i = i - 1) begin
                if (p[i]) begin
                    pick_slot = i[4:0]; // lowest slot, nearest the card
                end
            end
        end
    endfunction

    function [31:0] slot_bit;
        input [4:0] idx;
        begin
            slot_bit = 32'h0000_0001 << idx;
        end
    endfunction

    // ****************************************
    // link front ends
    // ****************************************
    wire ib_stb;
    wire ib_bit;
    wire ib_clk;
    wire ob_stb;
    wire ob_bit;
    wire ob_clk;

    slm_link_rx u_in_link (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .lclk_i(in_clk_i),
        .ldat_i(in_dat_i),
        .bit_stb_o(ib_stb),
        .bit_o(ib_bit),
        .lclk_o(ib_clk)
    );

    slm_link_rx u_out_link (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .lclk_i(out_clk_i),
        .ldat_i(out_dat_i),
        .bit_stb_o(ob_stb),
        .bit_o(ob_bit),
        .lclk_o(ob_clk)
    );

    // ****************************************
    // adapter pin synchronisers
    // ****************************************
    reg [31:0] req_s1_r;
    reg [31:0] req_s2_r;
    reg [11:0] byte_s1_r;
    reg [11:0] byte_s2_r;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_s1_r <= 32'h0000_0000;
            req_s2_r <= 32'h0000_0000;
            byte_s1_r <= 12'h000;
            byte_s2_r <= 12'h000;
        end else begin
            req_s1_r <= req_i;
            req_s2_r <= req_s1_r;
            byte_s1_r <= {in_last_i, in_byte_i};
            byte_s2_r <= byte_s1_r;
        end
    end

    wire last_s = byte_s2_r[11];
    wire [11:0] byte_cell = {byte_s2_r[10:0], 1'b0};

    // ****************************************
    // input loop framer
    // ****************************************
    reg [6:0] ist_r;
    reg [23:0] win_r;
    reg [3:0] bitcnt_r;
    reg [11:0] tx_r;
    reg [31:0] pend_r;
    reg [4:0] cur_r;
    reg [4:0] last_r;
    reg last_v_r;
    reg [3:0] bcnt_r;
    reg [7:0] icrc_r;
    reg [11:0] cell_out;

    wire [23:0] win_nxt = {win_r[22:0], ib_bit};
    wire [31:0] pend_left = pend_r & ~slot_bit(cur_r);
    wire [7:0] chk_val = crc_bits(icrc_r, {`SLM_ID_CHK, 8'h00}, `SLM_CRC_ID_BITS);

    always @* begin
        case (ist_r)
            ST_FRAME: cell_out = byte_cell;
            ST_CRC: cell_out = {`SLM_ID_CHK, chk_val};
            ST_END: cell_out = `SLM_CELL_LOOP_END;
            ST_ENDX: cell_out = `SLM_CELL_LOOP_END;
            default: cell_out = `SLM_CELL_EMPTY;
        endcase
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ist_r <= ST_HUNT;
            win_r <= 24'h00_0000;
            bitcnt_r <= 4'h0;
            tx_r <= 12'h000;
            pend_r <= 32'h0000_0000;
            cur_r <= 5'h00;
            last_r <= 5'h00;
            last_v_r <= 1'b0;
            bcnt_r <= 4'h0;
            icrc_r <= 8'h00;
            in_dat_o <= 1'b0;
            in_clk_o <= 1'b0;
            in_sel_o <= 32'h0000_0000;
            in_stb_o <= 1'b0;
            in_err_o <= 32'h0000_0000;
            in_sync_o <= 1'b0;
        end else begin
            in_stb_o <= 1'b0;
            in_err_o <= 32'h0000_0000;
            in_clk_o <= ib_clk;
            in_sync_o <= (ist_r != ST_HUNT);
            if (ist_r == ST_HUNT) begin
                pend_r <= pend_r | req_s2_r; // latch only while hunting
            end
            if (ib_stb) begin
                win_r <= win_nxt;
                if (win_nxt[11:0] == `SLM_CELL_RESTART && last_v_r) begin
                    in_err_o <= slot_bit(last_r);
                end
                if (ist_r == ST_HUNT) begin
                    if (bitcnt_r != 4'h0) begin
                        // closing cell still going out, pass-through waits for its end
                        in_dat_o <= tx_r[11];
                        tx_r <= {tx_r[10:0], 1'b0};
                        bitcnt_r <= (bitcnt_r == `SLM_LAST_BIT) ? 4'h0 : bitcnt_r + 4'h1;
                    end else begin
                        in_dat_o <= win_r[23];
                    end
                    if (pend_r != 32'h0000_0000 && win_nxt == `SLM_SYNC_PAT) begin
                        ist_r <= ST_FIRST;
                        bitcnt_r <= 4'h0;
                        cur_r <= pick_slot(pend_r);
                        in_sel_o <= slot_bit(pick_slot(pend_r));
                    end
                end else begin
                    bitcnt_r <= (bitcnt_r == `SLM_LAST_BIT) ? 4'h0 : bitcnt_r + 4'h1;
                    if (bitcnt_r != 4'h0) begin
                        in_dat_o <= tx_r[11];
                        tx_r <= {tx_r[10:0], 1'b0};
                    end else begin
                        in_dat_o <= cell_out[11];
                        tx_r <= {cell_out[10:0], 1'b0};
                        case (ist_r)
                            ST_FIRST: begin
                                ist_r <= ST_FRAME;
                                bcnt_r <= 4'h0;
                            end
                            ST_FRAME: begin
                                in_stb_o <= 1'b1;
                                icrc_r <= crc_bits((bcnt_r == 4'h0) ? 8'h00 : icrc_r,
                                    cell_out, `SLM_CELL_BITS);
                                bcnt_r <= bcnt_r + 4'h1;
                                if (last_s || bcnt_r == `SLM_LAST_BYTE) begin
                                    ist_r <= ST_CRC;
                                    in_sel_o <= 32'h0000_0000;
                                    pend_r <= pend_left;
                                    last_r <= cur_r;
                                    last_v_r <= 1'b1;
                                end
                            end
                            ST_CRC: begin
                                if (pend_r == 32'h0000_0000) begin
                                    ist_r <= ST_END;
                                end else if (win_r[11:0] == `SLM_CELL_EMPTY) begin
                                    ist_r <= ST_FRAME;
                                    bcnt_r <= 4'h0;
                                    cur_r <= pick_slot(pend_r);
                                    in_sel_o <= slot_bit(pick_slot(pend_r));
                                end else begin
                                    ist_r <= ST_ENDX;
                                end
                            end
                            ST_END: begin
                                ist_r <= ST_TAIL;
                            end
                            ST_TAIL: begin
                                ist_r <= ST_HUNT;
                            end
                            ST_ENDX: begin
                                ist_r <= ST_HUNT;
                            end
                            default: begin
                                ist_r <= ST_HUNT;
                            end
                        endcase
                    end
                end
            end
        end
    end

    // ****************************************
    // output loop distributor
    // ****************************************
    reg [11:0] owin_r;
    reg [3:0] obit_r;
    reg ofr_r;
    reg [4:0] ocnt_r;
    reg [7:0] ocrc_r;

    wire [11:0] ocell = {owin_r[10:0], ob_bit};
    wire [3:0] oid = ocell[11:8];
    wire oid_ok = (oid == `SLM_ID_EMPTY) || (oid == `SLM_ID_NULL) || (oid == `SLM_ID_ADDR)
        || (oid == `SLM_ID_DATA) || (oid == `SLM_ID_CHK) || (oid == `SLM_ID_LOOP_END)
        || (oid == `SLM_ID_RESTART);

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // all ones, so the cleared window cannot pass for an empty cell
            owin_r <= 12'hfff;
            obit_r <= 4'h0;
            ofr_r <= 1'b0;
            ocnt_r <= 5'h00;
            ocrc_r <= 8'h00;
            out_clk_o <= 1'b0;
            out_dat_o <= 1'b0;
            out_sync_o <= 1'b0;
            obus_data_o <= 11'h000;
            obus_addr_stb_o <= 1'b0;
            obus_data_stb_o <= 1'b0;
            obus_end_o <= 1'b0;
            obus_err_o <= 1'b0;
        end else begin
            obus_addr_stb_o <= 1'b0;
            obus_data_stb_o <= 1'b0;
            obus_end_o <= 1'b0;
            obus_err_o <= 1'b0;
            out_clk_o <= ob_clk;
            if (ob_stb) begin
                out_dat_o <= ob_bit; // every cell forwarded
                owin_r <= ocell;
                if (!out_sync_o) begin
                    if (ocell == `SLM_CELL_EMPTY) begin
                        out_sync_o <= 1'b1;
                        obit_r <= 4'h0;
                        ofr_r <= 1'b0;
                    end
                end else begin
                    obit_r <= (obit_r == `SLM_LAST_BIT) ? 4'h0 : obit_r + 4'h1;
                    if (obit_r == `SLM_LAST_BIT) begin
                        if (!oid_ok) begin
                            out_sync_o <= 1'b0; // lost alignment, wait for empty
                            if (ofr_r) begin
                                obus_end_o <= 1'b1;
                                obus_err_o <= 1'b1;
                            end
                            ofr_r <= 1'b0;
                        end else if (oid == `SLM_ID_ADDR) begin
                            ofr_r <= 1'b1;
                            ocnt_r <= 5'h01;
                            ocrc_r <= crc_bits(8'h00, ocell, `SLM_CELL_BITS);
                            obus_data_o <= ocell[11:1];
                            obus_addr_stb_o <= 1'b1;
                        end else if (ofr_r && oid == `SLM_ID_CHK) begin
                            ofr_r <= 1'b0;
                            obus_end_o <= 1'b1;
                            obus_err_o <= (ocell[7:0] !=
                                crc_bits(ocrc_r, ocell, `SLM_CRC_ID_BITS));
                        end else if (ofr_r && ocnt_r == `SLM_MAX_CELLS) begin
                            ofr_r <= 1'b0;
                            obus_end_o <= 1'b1;
                            obus_err_o <= 1'b1;
                        end else if (ofr_r) begin
                            ocnt_r <= ocnt_r + 5'h01;
                            ocrc_r <= crc_bits(ocrc_r, ocell, `SLM_CELL_BITS);
                            obus_data_o <= ocell[11:1];
                            obus_data_stb_o <= 1'b1;
                        end
                    end
                end
            end
        end
    end
endmodule

// [slm_link_src.sv]
// behavioural loop link source in place of the host loop adapter
`timescale 1ns/100ps
module slm_link_src (
    output logic clk_o,
    output logic dat_o
);
    initial begin
        clk_o = 1'b0;
        dat_o = 1'b1;
    end
    // one cell msb first, data set while clock low; clock idles low after
    // line turns to the inverse of the last bit mid-way through its high phase
    task automatic send_cell(input logic [11:0] c);
        for (int i = 11; i >= 0; i--) begin
            dat_o = c[i];
            #40 clk_o = 1'b1;
            #20;
            if (i == 0) dat_o = ~c[0];
            #20 clk_o = 1'b0;
        end
    endtask
endmodule

// [slm_mux_asserts.sv]
// port checks for the loop multiplexer
`timescale 1ns/100ps
module slm_mux_asserts (
    input wire clk_i,
    input wire rstn_i,
    input wire in_clk_i,
    input wire in_clk_o,
    input wire [31:0] in_sel_o,
    input wire in_stb_o,
    input wire [31:0] in_err_o,
    input wire in_sync_o,
    input wire obus_addr_stb_o,
    input wire obus_data_stb_o,
    input wire obus_end_o,
    input wire obus_err_o,
    input wire out_sync_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // ****************************************
    // bytes taken per grant, change cycles ignored
    // ****************************************
    logic [4:0] stb_cnt_r;
    logic [31:0] sel_r;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stb_cnt_r <= 5'h00;
            sel_r <= 32'h0000_0000;
        end else begin
            sel_r <= in_sel_o;
            if (in_sel_o != sel_r) begin
                stb_cnt_r <= 5'h00;
            end else begin
                stb_cnt_r <= stb_cnt_r + {4'h0, in_stb_o};
            end
        end
    end
    byte_limit_a: assert property (stb_cnt_r <= 5'h10)
        else $error("more than sixteen bytes taken from one adapter");
    stb_pulse_a: assert property (in_stb_o |=> !in_stb_o [*8])
        else $error("byte strobes too close");
    stb_has_sel_a: assert property (in_stb_o |-> $onehot($past(in_sel_o)))
        else $error("byte taken with no single adapter selected");
    sel_in_sync_a: assert property ($rose(|in_sel_o) |-> ##[0:1] in_sync_o)
        else $error("adapter selected while not synchronized");
    err_onehot_a: assert property ($onehot0(in_err_o))
        else $error("restart error sent to several adapters");
    err_with_end_a: assert property (obus_err_o |-> obus_end_o)
        else $error("output error without frame end");
    strobe_excl_a: assert property
        ($onehot0({obus_addr_stb_o, obus_data_stb_o, obus_end_o}))
        else $error("output bus strobes overlap");
    addr_in_sync_a: assert property (obus_addr_stb_o |-> out_sync_o)
        else $error("address strobe while output loop unsynchronized");
    in_regen_a: assert property ($rose(in_clk_i) |-> ##[4:9] $rose(in_clk_o))
        else $error("input loop clock not regenerated in time");
endmodule
bind slm_loop_mux slm_mux_asserts u_asserts (.clk_i(clk_i), .rstn_i(rstn_i),
    .in_clk_i(in_clk_i), .in_clk_o(in_clk_o), .in_sel_o(in_sel_o), .in_stb_o(in_stb_o),
    .in_err_o(in_err_o), .in_sync_o(in_sync_o), .obus_addr_stb_o(obus_addr_stb_o),
    .obus_data_stb_o(obus_data_stb_o), .obus_end_o(obus_end_o), .obus_err_o(obus_err_o),
    .out_sync_o(out_sync_o));

// [test_slm_loop_mux.sv]
// self-checking bench for the serial loop multiplexer
`timescale 1ns/100ps
module test_slm_loop_mux;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic in_clk_i, in_dat_i, out_clk_i, out_dat_i, in_clk_o, in_dat_o, out_clk_o, out_dat_o;
    logic in_stb_o, in_sync_o, out_sync_o, obus_addr_stb_o, obus_data_stb_o, obus_end_o;
    logic obus_err_o;
    logic [31:0] req_i = 32'h0000_0000;
    logic [10:0] in_byte_i = 11'h000;
    logic in_last_i = 1'b0;
    logic [31:0] in_sel_o, in_err_o;
    logic [10:0] obus_data_o;
    logic [31:0] err_seen = 32'h0000_0000;
    int err_count = 0;
    int comparisons = 0;
    int cur = -1;
    int err_n = 0;
    int cexp[$];
    int fseq[$];
    int sel_seen[$];
    logic [11:0] cin[$];
    logic [11:0] ocells[$];
    logic [14:0] orec[$];
    logic [14:0] oexp[$];
    logic obits[$];
    logic oobits[$];
    logic [10:0] abytes[32][$];
    bit alast[32];

    always #5 clk_i = ~clk_i;
    slm_link_src u_isrc (.clk_o(in_clk_i), .dat_o(in_dat_i));
    slm_link_src u_osrc (.clk_o(out_clk_i), .dat_o(out_dat_i));
    slm_loop_mux u_slm_loop_mux (.clk_i(clk_i), .rstn_i(rstn_i), .in_clk_i(in_clk_i),
        .in_dat_i(in_dat_i), .in_clk_o(in_clk_o), .in_dat_o(in_dat_o), .out_clk_i(out_clk_i),
        .out_dat_i(out_dat_i), .out_clk_o(out_clk_o), .out_dat_o(out_dat_o), .req_i(req_i),
        .in_byte_i(in_byte_i), .in_last_i(in_last_i), .in_sel_o(in_sel_o),
        .in_stb_o(in_stb_o), .in_err_o(in_err_o), .in_sync_o(in_sync_o),
        .obus_data_o(obus_data_o), .obus_addr_stb_o(obus_addr_stb_o),
        .obus_data_stb_o(obus_data_stb_o), .obus_end_o(obus_end_o),
        .obus_err_o(obus_err_o), .out_sync_o(out_sync_o));

    // ****************************************
    // adapter cards and monitors
    // ****************************************
    always @(posedge clk_i) begin
        #1;
        if (in_stb_o === 1'b1 && cur >= 0 && abytes[cur].size() > 0)
            void'(abytes[cur].pop_front());
        for (int s = 0; s < 32; s++) begin
            if (in_sel_o[s] === 1'b1 && s != cur) begin
                cur = s;
                sel_seen.push_back(s);
            end
        end
        if (cur >= 0 && in_sel_o[cur] === 1'b1) begin
            req_i[cur] = 1'b0;
            in_byte_i = (abytes[cur].size() > 0) ? abytes[cur][0] : 11'h000;
            in_last_i = alast[cur] && abytes[cur].size() == 1;
        end
        if (in_err_o !== 32'h0000_0000) begin
            err_seen = in_err_o;
            err_n++;
        end
        if (obus_addr_stb_o === 1'b1) orec.push_back({4'h1, obus_data_o});
        if (obus_data_stb_o === 1'b1) orec.push_back({4'h2, obus_data_o});
        if (obus_end_o === 1'b1) orec.push_back({obus_err_o === 1'b1 ? 4'h4 : 4'h3, 11'h000});
    end
    always @(posedge in_clk_o) obits.push_back(in_dat_o);
    always @(posedge out_clk_o) oobits.push_back(out_dat_o);

    // ****************************************
    // reference model and helpers
    // ****************************************
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [11:0] v,
                                            input int n);
        for (int i = 11; i > 11 - n; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'hc3 : 8'h00);
        return c;
    endfunction
    task automatic put(input logic [11:0] c, input int e);
        cin.push_back(c);
        cexp.push_back(e);
    endtask
    task automatic filler(input int n);
        logic [11:0] v;
        for (int i = 0; i < n; i++) begin
            // id 3 and a zero last bit: the cell itself never matches a restart cell
            v = {4'h3, 1'b0, 6'($urandom), 1'b0};
            put(v, v);
        end
    endtask
    task automatic load_slot(input int s, input int n, input bit lst);
        logic [7:0] c;
        logic [11:0] v;
        c = 8'h00;
        for (int i = 0; i < n; i++) begin
            v = {(i == 0) ? 4'h2 : 4'h3, 7'($urandom), 1'b0};
            abytes[s].push_back(v[11:1]);
            if (i < 16) begin
                fseq.push_back(v);
                c = crc_step(c, v, 12);
            end
        end
        alast[s] = lst;
        fseq.push_back({4'h4, crc_step(c, 12'h400, 4)});
    endtask
    task automatic out_frame(input int n, input bit bad);
        logic [7:0] c;
        logic [11:0] v;
        c = 8'h00;
        for (int i = 0; i < n; i++) begin
            v = {(i == 0) ? 4'h2 : 4'h3, 7'($urandom), 1'b0};
            c = crc_step(c, v, 12);
            ocells.push_back(v);
            if (i < 16) oexp.push_back({(i == 0) ? 4'h1 : 4'h2, v[11:1]});
        end
        ocells.push_back({4'h4, crc_step(c, 12'h400, 4) ^ {7'h00, bad}});
        oexp.push_back((bad || n > 16) ? 15'h2000 : 15'h1800);
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_sync();
        int n;
        n = 0;
        while (in_sync_o !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000) begin
            err_count++;
            conclude();
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        #400_000;
        err_count++;
        conclude();
    end
    initial begin
        int a;
        int b;
        logic [11:0] v;
        void'($urandom(32'h9a16));
        a = 8 + $urandom % 10;
        b = a + 1 + $urandom % 13;
        repeat (8) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        load_slot(a, 3, 1'b1);
        load_slot(b, 18, 1'b0);
        req_i[a] = 1'b1;
        req_i[b] = 1'b1;
        filler(4);
        put(12'he00, 12'h000);
        foreach (fseq[i]) put(12'h000, fseq[i]);
        put(12'h000, 12'he00);
        put(12'h000, 12'h000);
        fseq.delete();
        filler(3);
        load_slot(0, 2, 1'b1);
        put(12'he00, 12'h000);
        foreach (fseq[i]) put(12'h000, fseq[i]);
        put(12'h100, 12'he00);
        put(12'h000, -1);
        put(12'h000, -1);
        put(12'hf00, 12'hf00);
        filler(3);
        put(12'h000, -1);
        put(12'h000, -1);
        load_slot(7, 2, 1'b1);
        ocells = '{12'h000, 12'h000};
        out_frame(4, 1'b0);
        out_frame(2, 1'b1);
        out_frame(17, 1'b0);
        ocells.push_back(12'h000);
        out_frame(1, 1'b0);
        ocells.push_back(12'h000);
        fork
            foreach (cin[i]) u_isrc.send_cell(cin[i]);
            begin
                #17;
                foreach (ocells[i]) u_osrc.send_cell(ocells[i]);
            end
            begin
                wait_sync();
                @(posedge clk_i);
                #1;
                req_i[0] = 1'b1;
                req_i[7] = 1'b1;
            end
        join
        repeat (300) @(posedge clk_i);
        $display("test loop traffic done");
        check("input loop bit count", 1, obits.size() >= 12 * cin.size());
        for (int m = 2; m < cin.size(); m++) begin
            for (int k = 0; k < 12; k++) v = {v[10:0], obits[12 * m + k]};
            if (cexp[m - 2] >= 0) check("input loop cell", cexp[m - 2], v);
        end
        check("output loop bit count", 12 * ocells.size(), oobits.size());
        foreach (ocells[i]) begin
            for (int k = 0; k < 12; k++) begin
                check("output loop bit", ocells[i][11 - k], oobits[12 * i + k]);
            end
        end
        check("output record count", oexp.size(), orec.size());
        foreach (oexp[i]) check("output record", oexp[i], orec[i]);
        check("grant count", 3, sel_seen.size());
        check("first grant", a, sel_seen[0]);
        check("second grant", b, sel_seen[1]);
        check("third grant", 0, sel_seen[2]);
        check("restart reports", 1, err_n);
        check("restart target", 32'h0000_0001, err_seen);
        $display("test result checks done");
        conclude();
    end
endmodule
